// ### design/hf_echo_top.v
// half-full flag, echo read clock and strobe, offset shifter, output width
`timescale 1ns/10ps
`include "hf_echo_map.vh"
module hf_echo_top #(
  parameter [`PTR_W-1:0] CMP_DEPTH = `NATIVE_DEPTH // word depth for the half-full compare
) (
  input  wire                 CLOCK,          // 50 MHz block clock
  input  wire                 RST_N,          // async reset, active low
  input  wire                 MASTER_RESET_N, // pin: master reset
  input  wire                 PARTIAL_RESET_N,// pin: partial reset
  input  wire                 FALL_THROUGH_MODE, // pin: 1 = first word fall through
  input  wire                 WIDE_IN,        // pin: input port 18 bits
  input  wire                 WIDE_OUT,       // pin: output port 18 bits
  input  wire                 WRITE_CLOCK,    // pin: writer clock
  input  wire                 WRITE_EN_N,     // pin: write enable
  input  wire [`DATA_W-1:0]   WRITE_DATA,     // pin: write word
  output wire                 WRITE_READY,    // link fifo has room
  input  wire                 READ_CLOCK,     // pin: reader clock
  input  wire                 READ_EN_N,      // pin: read enable
  input  wire                 READ_SELECT_N,  // pin: read chip select
  input  wire                 SERIAL_CLOCK,   // pin: offset serial clock
  input  wire                 OFFSET_SERIAL_ENABLE_N, // pin: serial enable
  input  wire                 SERIAL_IN,      // pin: serial data
  output reg  [`OFFSET_W-1:0] OFFSET_VALUE,   // shifted offset register
  output reg                  HALF_FULL_N,    // half-full flag
  output reg                  EMPTY_N,        // empty flag, standard mode
  output reg                  ECHO_READ_CLOCK,// echo of read clock
  output reg                  ECHO_READ_STROBE_N, // low for a read cycle
  output reg  [`DATA_W-1:0]   READ_DATA_OUT   // output data lines
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  reg  [1:0] rst_sync;
  wire       rst_n = rst_sync[1];
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N) rst_sync <= 2'h0;
    else        rst_sync <= {rst_sync[0], 1'b1};
  end

  localparam NS = 7;
  wire [NS-1:0] pin_raw = {MASTER_RESET_N, PARTIAL_RESET_N, WRITE_CLOCK, READ_CLOCK,
                           SERIAL_CLOCK, OFFSET_SERIAL_ENABLE_N, SERIAL_IN};
  reg  [NS-1:0] s1_reg;
  reg  [NS-1:0] s2_reg;
  reg  [NS-1:0] s3_reg;   // previous sample, for edge detection
  // two flops per pin, then one more for edges
  always @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 7'h63;
      s2_reg <= 7'h63;
      s3_reg <= 7'h63;
    end
    else
    begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  wire mrs_n   = s2_reg[6];
  wire prs_n   = s2_reg[5];
  wire wclk_up = s2_reg[4] & ~s3_reg[4];
  wire rclk_up = s2_reg[3] & ~s3_reg[3];
  wire sclk_up = s2_reg[2] & ~s3_reg[2];
  wire clr     = ~mrs_n | ~prs_n;

  // data and write enable taken a further two flops so they align with the edge
  reg  [`DATA_W:0] wd1_reg;
  reg  [`DATA_W:0] wd2_reg;
  always @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wd1_reg <= {(`DATA_W+1){1'b1}};
      wd2_reg <= {(`DATA_W+1){1'b1}};
    end
    else
    begin
      wd1_reg <= {WRITE_EN_N, WRITE_DATA};
      wd2_reg <= wd1_reg;
    end
  end
  reg  [1:0] rd1_reg;
  reg  [1:0] rd2_reg;
  always @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd1_reg <= 2'h3;
      rd2_reg <= 2'h3;
    end
    else
    begin
      rd1_reg <= {READ_EN_N, READ_SELECT_N};
      rd2_reg <= rd1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode pins are static in use, but still pass two flops like every pin
  reg  [2:0] cfg1_reg;
  reg  [2:0] cfg2_reg;
  always @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg1_reg <= 3'h3;
      cfg2_reg <= 3'h3;
    end
    else
    begin
      cfg1_reg <= {FALL_THROUGH_MODE, WIDE_IN, WIDE_OUT};
      cfg2_reg <= cfg1_reg;
    end
  end
  wire fall_through_mode_on  = cfg2_reg[2];
  wire wide_in  = cfg2_reg[1];
  wire wide_out = cfg2_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // data path: link fifo absorbs writes, read edge pops
  // writes that find the link fifo full are lost; WRITE_READY warns the writer
  wire               wr_req = wclk_up & ~wd2_reg[`DATA_W];
  wire               f_valid;
  wire [`DATA_W-1:0] f_data;
  wire               rd_ok = ~rd2_reg[1] & ~rd2_reg[0] & f_valid;
  wire               rd_go = rclk_up & rd_ok;
  link_fifo #(.W(`DATA_W), .D(`LINK_DEPTH), .AW(`LINK_AW)) u_fifo (
    .clk       (CLOCK),
    .rst_n     (rst_n),
    .flush     (clr),
    .in_data   (wd2_reg[`DATA_W-1:0]),
    .in_valid  (wr_req),
    .in_ready  (WRITE_READY),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (rd_go)
  );

  ////////////////////////////////////////////////////////////////////////////
  // word-count pointers for the half-full compare; they count accepted words
  // only, so the flag can trip only while the compare depth is small against
  // what the link fifo holds; dropped writes never move the count
  reg  [`PTR_W-1:0] wptr_reg;
  reg  [`PTR_W-1:0] rptr_reg;
  wire              wr_acc = wr_req & WRITE_READY;
  wire              narrow_both = ~wide_in & ~wide_out;
  // limit: compare depth, doubled for nine-bit both ways; fall_through_mode adds one word
  wire [`PTR_W-1:0] depth = narrow_both ? {CMP_DEPTH[`PTR_W-2:0], 1'b0}
                                        : CMP_DEPTH;
  wire [`PTR_W-1:0] half  = fall_through_mode_on ? {1'b0, depth[`PTR_W-1:1]} + 13'h0001
                                    : {1'b0, depth[`PTR_W-1:1]};
  wire [`PTR_W-1:0] cnt_after_wr = wptr_reg + 13'h0001 - rptr_reg;
  wire [`PTR_W-1:0] cnt_after_rd = wptr_reg - rptr_reg - 13'h0001;
  always @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_reg    <= 13'h0000;
      rptr_reg    <= 13'h0000;
      HALF_FULL_N <= 1'b1;
    end
    else if (clr)
    begin
      wptr_reg    <= 13'h0000;
      rptr_reg    <= 13'h0000;
      HALF_FULL_N <= 1'b1;
    end
    else
    begin
      if (wr_acc) wptr_reg <= wptr_reg + 13'h0001;
      if (rd_go)  rptr_reg <= rptr_reg + 13'h0001;
      // write side sets, read side clears; flag is asynchronous to both clocks
      if (wr_acc && !rd_go && cnt_after_wr > half)
        HALF_FULL_N <= 1'b0;
      else if (rd_go && !wr_acc && cnt_after_rd <= half)
        HALF_FULL_N <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // echo clock, echo strobe, empty flag and output register
  // the echo trails the read clock by the synchroniser depth plus one flop,
  // so it moves on the same edge as the output lines, never ahead of them
  always @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ECHO_READ_CLOCK    <= 1'b0;
      ECHO_READ_STROBE_N <= 1'b1;
      EMPTY_N            <= 1'b0;
      READ_DATA_OUT      <= 18'h00000;
    end
    else
    begin
      ECHO_READ_CLOCK <= s2_reg[3]; // free running, ignores enables
      if (rclk_up)
        ECHO_READ_STROBE_N <= ~rd_ok;
      EMPTY_N <= f_valid & ~clr;
      if (rd_go)
        READ_DATA_OUT <= wide_out ? f_data
                                  : {9'h000, f_data[8:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial offset shifter; partial reset keeps programmed settings
  always @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
      OFFSET_VALUE <= 12'h000;
    else if (!mrs_n)
      OFFSET_VALUE <= 12'h000;
    else if (sclk_up && !s2_reg[1])
      OFFSET_VALUE <= {OFFSET_VALUE[`OFFSET_W-2:0], s2_reg[0]};
  end
endmodule // hf_echo_top

// ### design/hf_echo_map.vh
// constants for the half-full and echo read output block
// How it works
// - half-full goes low on the write edge taking count above half depth
// - half-full returns high on the read edge bringing count to half or less
// - standard mode trips after half depth plus one writes from reset
// - compare depth is native depth, doubled when both ports are nine bits
// - fall-through mode adds the output word; trips after D/2 plus two writes
// - half-full is touched by both sides, so receivers synchronise it
// - echo read clock follows the read clock whatever the enables do
// - echo strobe goes low at a read clock rise with read and select low and not empty, and holds until the next rise
// - offset bits shift in on serial clock rise only while enable is low
// - output uses eighteen lines, or the low nine in nine-bit width
// - standard mode empty flag low while empty, and reads are held off
`ifndef HF_ECHO_MAP_VH
`define HF_ECHO_MAP_VH
`define NATIVE_DEPTH   13'h0800
`define PTR_W          13
`define DATA_W         18
`define OFFSET_W       12
`define LINK_DEPTH     8
`define LINK_AW        3
`endif

// ### design/link_fifo.v
// small parameterised fifo with valid and ready on both sides
`timescale 1ns/10ps
module link_fifo #(
  parameter W  = 18,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          clk,      // block clock
  input  wire          rst_n,    // synchronised reset
  input  wire          flush,    // drop everything
  input  wire [W-1:0]  in_data,  // write word
  input  wire          in_valid, // write request
  output wire          in_ready, // space free
  output wire [W-1:0]  out_data, // head word
  output wire          out_valid,// head valid
  input  wire          out_ready // head taken
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW:0]   wp_reg;
  reg [AW:0]   rp_reg;
  wire         do_wr = in_valid & in_ready;
  wire         do_rd = out_valid & out_ready;
  // full when the low bits meet and the wrap bits differ
  assign in_ready  = ~((wp_reg[AW-1:0] == rp_reg[AW-1:0]) & (wp_reg[AW] ^ rp_reg[AW]));
  assign out_valid = wp_reg != rp_reg;
  assign out_data  = mem[rp_reg[AW-1:0]];
  // pointers carry an extra wrap bit so full and empty stay distinct
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_reg <= {(AW+1){1'b0}};
      rp_reg <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wp_reg <= {(AW+1){1'b0}};
      rp_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr) wp_reg <= wp_reg + 1'b1;
      if (do_rd) rp_reg <= rp_reg + 1'b1;
    end
  end
  // storage array, no reset needed
  always @(posedge clk)
  begin
    if (do_wr) mem[wp_reg[AW-1:0]] <= in_data;
  end
endmodule // link_fifo

// ### verif/half_echo_chk.sv
// assertions on the flag, echo and output pins
`timescale 1ns/10ps
`include "hf_echo_map.vh"
module half_echo_chk (
  input wire                 CLOCK,                  // block clock
  input wire                 RST_N,                  // async reset
  input wire                 MASTER_RESET_N,         // master reset pin
  input wire                 WIDE_OUT,               // output width
  input wire                 READ_CLOCK,             // reader clock
  input wire                 OFFSET_SERIAL_ENABLE_N, // serial enable
  input wire [`OFFSET_W-1:0] OFFSET_VALUE,           // offset register
  input wire                 HALF_FULL_N,            // half-full flag
  input wire                 EMPTY_N,                // empty flag
  input wire                 ECHO_READ_CLOCK,        // echo clock
  input wire                 ECHO_READ_STROBE_N,     // echo strobe
  input wire [`DATA_W-1:0]   READ_DATA_OUT           // output lines
);
  // one clock domain, so clocking and disable are given once
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  chk_flag_reset: assert property ($rose(MASTER_RESET_N) |->
    HALF_FULL_N && !EMPTY_N) else $error("flags not cleared by master reset");
  chk_empty_clear: assert property ($fell(MASTER_RESET_N) |->
    ##[1:5] !EMPTY_N) else $error("empty flag late after master reset");
  chk_echo_follow: assert property ($rose(READ_CLOCK) |->
    ##[1:5] $rose(ECHO_READ_CLOCK)) else $error("echo clock missed a read clock rise");
  chk_echo_still: assert property ($stable(READ_CLOCK) [*6] |->
    $stable(ECHO_READ_CLOCK)) else $error("echo clock moved without read clock");
  chk_strobe_cause: assert property ($fell(ECHO_READ_STROBE_N) |->
    $past(EMPTY_N)) else $error("strobe fell while empty");
  chk_strobe_hold: assert property ($fell(ECHO_READ_STROBE_N) |->
    !ECHO_READ_STROBE_N [*4]) else $error("strobe too short");
  chk_narrow_bus: assert property ($fell(ECHO_READ_STROBE_N) && !WIDE_OUT |->
    READ_DATA_OUT[17:9] == 9'h000) else $error("upper lines driven in narrow width");
  chk_empty_half: assert property (!EMPTY_N |-> HALF_FULL_N)
    else $error("half-full low while empty");
  chk_offset_hold: assert property ((OFFSET_SERIAL_ENABLE_N && MASTER_RESET_N) [*5] |->
    $stable(OFFSET_VALUE)) else $error("offset moved while disabled");
endmodule // half_echo_chk
bind hf_echo_top half_echo_chk half_echo_chk_i (.CLOCK(CLOCK), .RST_N(RST_N),
  .MASTER_RESET_N(MASTER_RESET_N), .WIDE_OUT(WIDE_OUT), .READ_CLOCK(READ_CLOCK),
  .OFFSET_SERIAL_ENABLE_N(OFFSET_SERIAL_ENABLE_N), .OFFSET_VALUE(OFFSET_VALUE),
  .HALF_FULL_N(HALF_FULL_N), .EMPTY_N(EMPTY_N), .ECHO_READ_CLOCK(ECHO_READ_CLOCK),
  .ECHO_READ_STROBE_N(ECHO_READ_STROBE_N), .READ_DATA_OUT(READ_DATA_OUT));

// ### verif/pin_partner.sv
// pin model of the writer, the reader and the offset programmer
`timescale 1ns/10ps
module pin_partner (
  input  wire         clk,      // block clock
  output logic        wclk,     // writer clock
  output logic        wen_n,    // write enable
  output logic [17:0] wdata,    // write word
  output logic        rclk,     // reader clock
  output logic        ren_n,    // read enable
  output logic        rsel_n,   // read select
  output logic        sclk,     // serial clock
  output logic        ser_en_n, // serial enable
  output logic        ser_bit   // serial data
);
  // clocks stand still between frames, so the block sees only real edges
  initial {wclk, wen_n, wdata, rclk, ren_n, rsel_n, sclk, ser_en_n, ser_bit} =
    {1'b0, 1'b1, 18'h15555, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  // one 160 ns link period; the caller spends the first low cycle setting up
  task automatic cyc(input logic w, input logic r, input logic s);
    repeat (3) @(posedge clk);
    #1 {wclk, rclk, sclk} = {w, r, s};
    repeat (4) @(posedge clk);
    #1 {wclk, rclk, sclk} = 3'b000;
  endtask
  // released data lines show the inverse, never a stale copy
  task automatic put(input logic [17:0] d);
    @(posedge clk) #1 {wen_n, wdata} = {1'b0, d};
    cyc(1'b1, 1'b0, 1'b0);
    {wen_n, wdata} = {1'b1, ~d};
  endtask
  task automatic get;
    @(posedge clk) #1 {ren_n, rsel_n} = 2'b00;
    cyc(1'b0, 1'b1, 1'b0);
    {ren_n, rsel_n} = 2'b11;
  endtask
  // bit is set while the serial clock is low, before its rise
  task automatic sh(input logic e, input logic b);
    @(posedge clk) #1 {ser_en_n, ser_bit} = {e, b};
    cyc(1'b0, 1'b0, 1'b1);
  endtask
endmodule // pin_partner

// ### verif/test_fifo_half_full_echo_outputs.sv
// testbench for the half-full flag, echo outputs and offset shifter
`timescale 1ns/10ps
module test_fifo_half_full_echo_outputs;
  logic clk = 1'b0, rst_n = 1'b0, mreset_n = 1'b1, preset_n = 1'b1, wide_out = 1'b1;
  logic fall_through_mode = 1'b0, wide_in = 1'b1;
  wire wclk, wen_n, rclk, ren_n, rsel_n, sclk, ser_en_n, ser_bit, wr_ready;
  wire half_n, empty_n, echo_clk, echo_stb_n;
  wire [17:0] wdata, rdata;
  wire [11:0] offset;
  int err_total = 0, checks = 0;
  // compare depth shrunk to eight so the flag trips within the link fifo
  hf_echo_top #(.CMP_DEPTH(13'h0008)) hf_echo_top_i (.CLOCK(clk), .RST_N(rst_n),
    .MASTER_RESET_N(mreset_n), .PARTIAL_RESET_N(preset_n), .FALL_THROUGH_MODE(fall_through_mode),
    .WIDE_IN(wide_in), .WIDE_OUT(wide_out),
    .WRITE_CLOCK(wclk), .WRITE_EN_N(wen_n), .WRITE_DATA(wdata), .WRITE_READY(wr_ready),
    .READ_CLOCK(rclk), .READ_EN_N(ren_n), .READ_SELECT_N(rsel_n), .SERIAL_CLOCK(sclk),
    .OFFSET_SERIAL_ENABLE_N(ser_en_n), .SERIAL_IN(ser_bit), .OFFSET_VALUE(offset),
    .HALF_FULL_N(half_n), .EMPTY_N(empty_n), .ECHO_READ_CLOCK(echo_clk),
    .ECHO_READ_STROBE_N(echo_stb_n), .READ_DATA_OUT(rdata));
  pin_partner pin_partner_i (.clk(clk), .wclk(wclk), .wen_n(wen_n), .wdata(wdata), .rclk(rclk),
    .ren_n(ren_n), .rsel_n(rsel_n), .sclk(sclk), .ser_en_n(ser_en_n), .ser_bit(ser_bit));
  task chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // width is only changed while the master reset is held
  task mreset(input logic w, input logic wi = 1'b1, input logic ft = 1'b0);
    @(posedge clk) #1 mreset_n = 1'b0;
    {wide_out, wide_in, fall_through_mode} = {w, wi, ft};
    repeat (6) @(posedge clk);
    #1 mreset_n = 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // fill past the buffer, then drain it and read once more while empty
  task t_fill;
    mreset(1'b1);
    chk("empty", empty_n, 18'h0);
    chk("half", half_n, 18'h1);
    for (int i = 0; i < 9; i++)
    begin
      pin_partner_i.put(18'h2A000 + 18'(i));
      chk("half", half_n, {17'h00000, i < 4});
    end
    chk("ready", wr_ready, 18'h0);
    chk("half", half_n, 18'h0);
    for (int i = 0; i < 8; i++)
    begin
      pin_partner_i.get;
      chk("data", rdata, 18'h2A000 + 18'(i));
      chk("strobe", echo_stb_n, 18'h0);
      chk("half", half_n, {17'h00000, i > 2});
    end
    pin_partner_i.get;
    chk("strobe", echo_stb_n, 18'h1);
    chk("empty", empty_n, 18'h0);
  endtask
  // fall-through adds a word to the trip count; nine-bit both ways doubles depth
  task t_modes;
    mreset(1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      pin_partner_i.put(18'h01000 + 18'(i));
      chk("half", half_n, {17'h00000, i < 5});
    end
    pin_partner_i.get;
    chk("data", rdata, 18'h01000);
    chk("half", half_n, 18'h1);
    mreset(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) pin_partner_i.put(18'h00100 + 18'(i));
    chk("ready", wr_ready, 18'h0);
    chk("half", half_n, 18'h1);
  endtask
  task t_narrow;
    mreset(1'b0);
    pin_partner_i.put(18'h3FFFF);
    pin_partner_i.get;
    chk("narrow", rdata, 18'h001FF);
  endtask
  // partial reset must empty the store yet keep the offset
  task t_shift;
    mreset(1'b1);
    for (int i = 11; i >= 0; i--) pin_partner_i.sh(1'b0, 1'(12'hA5C >> i));
    chk("offset", offset, 18'h00A5C);
    pin_partner_i.sh(1'b1, 1'b1);
    pin_partner_i.sh(1'b1, 1'b0);
    chk("offset", offset, 18'h00A5C);
    pin_partner_i.put(18'h00123);
    chk("empty", empty_n, 18'h1);
    @(posedge clk) #1 preset_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 preset_n = 1'b1;
    repeat (4) @(posedge clk);
    chk("empty", empty_n, 18'h0);
    chk("keep", offset, 18'h00A5C);
  endtask
  task end_sim;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // free clock, 20 ns period
  initial
  begin
    forever #10 clk = ~clk;
  end
  // whole run is just under ten microseconds; this bound only catches a hang
  initial
  begin
    #100000;
    err_total++;
    end_sim;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    chk("half", half_n, 18'h1);
    chk("strobe", echo_stb_n, 18'h1);
    chk("data", rdata, 18'h0);
    t_fill;
    t_modes;
    t_narrow;
    t_shift;
    end_sim;
  end
endmodule // test_fifo_half_full_echo_outputs
